// ===== common/spi_pkg.sv
// shared constants, types and helpers of the serial peripheral controller
package spi_pkg;

  // register offsets on the plain register port
  localparam logic [1:0] ctrl_offset = 2'h0;
  localparam logic [1:0] status_offset = 2'h1;
  localparam logic [1:0] data_offset = 2'h2;

  // status register bit positions
  localparam int status_done_pos = 7;
  localparam int status_write_collision_flag_pos = 6;
  localparam int status_mode_fault_flag_pos = 4;

  // reset values
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] data_reset = 8'h00;
  localparam logic [3:0] edge_cnt_reset = 4'h0;
  localparam logic [6:0] div_cnt_reset = 7'h00;

  // serial clock edge indices within one byte (two edges per bit)
  localparam logic [3:0] edge_last = 4'hf;
  localparam logic [3:0] edge_last_lead = 4'he;

  // control register layout, msb first
  typedef struct packed {
    logic rate_sel_bit2;
    logic module_enable;
    logic select_disable;
    logic master_select;
    logic clk_polarity;
    logic clk_phase;
    logic rate_sel_bit1;
    logic rate_sel_bit0;
  } ctrl_t;

  // master engine states
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_run = 2'b10
  } mstate_t;

  // half period of the serial clock in peripheral clocks, minus one
  function automatic logic [6:0] half_period_m1(input logic [2:0] code);
    logic [6:0] r;
    r = 7'h00;
    unique case (code)
      3'h1: r = 7'h01;
      3'h2: r = 7'h03;
      3'h3: r = 7'h07;
      3'h4: r = 7'h0f;
      3'h5: r = 7'h1f;
      3'h6: r = 7'h3f;
      default: r = 7'h00;
    endcase
    return r;
  endfunction

  // codes zero and seven give no baud generator
  function automatic logic rate_valid(input logic [2:0] code);
    return (code != 3'h0) && (code != 3'h7);
  endfunction

endpackage

// ===== hdl/spi_master_slave_controller.sv
// serial peripheral controller, master or slave, one byte per transfer
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module spi_master_slave_controller (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n,
  input wire logic ss_n_i,
  output logic err_req
);

  // control and status state
  spi_pkg::ctrl_t ctrl_q;
  logic done_q;
  logic write_collision_flag_q;
  logic mode_fault_flag_q;
  logic done_arm_q;
  logic write_collision_flag_arm_q;
  logic mode_fault_flag_arm_q;
  logic [7:0] rx_q;
  logic [7:0] rdata_q;

  // shifter and clocking state
  spi_pkg::mstate_t mstate_q;
  logic [7:0] shift_q;
  logic out_q;
  logic [3:0] edge_cnt_q;
  logic [6:0] div_cnt_q;
  logic sck_lvl_q;
  logic [1:0] msamp_q;
  logic [1:0] mfin_q;
  logic [7:0] mrx_q;

  // pin synchronisers: bit 3 select, 2 clock, 1 mosi, 0 miso
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic sck_prev_q;
  logic ss_prev_q;

  // decoded accesses
  logic ctrl_wr;
  logic status_rd;
  logic status_acc;
  logic data_rd;
  logic data_wr;
  logic data_acc;

  // mode and transfer terms
  logic [2:0] rate_code;
  logic master_mode;
  logic slave_mode;
  logic ss_n_sync;
  logic sck_sync;
  logic selected;
  logic active;
  logic start;
  logic m_edge;
  logic s_edge;
  logic edge_now;
  logic is_lead;
  logic sample_edge;
  logic shift_edge;
  logic in_bit;
  logic finish;
  logic done_set;
  logic [7:0] shifted;
  logic mode_fault_flag_set;
  logic done_clr;
  logic write_collision_flag_clr;
  logic mode_fault_flag_clr;

  // register port decode
  assign ctrl_wr = reg_wr && (reg_addr == spi_pkg::ctrl_offset);
  assign status_rd = reg_rd && (reg_addr == spi_pkg::status_offset);
  assign status_acc = (reg_rd || reg_wr) && (reg_addr == spi_pkg::status_offset);
  assign data_rd = reg_rd && (reg_addr == spi_pkg::data_offset);
  assign data_wr = reg_wr && (reg_addr == spi_pkg::data_offset);
  assign data_acc = data_rd || data_wr;

  // mode selection, gated by the enable bit
  assign rate_code = {ctrl_q.rate_sel_bit2, ctrl_q.rate_sel_bit1, ctrl_q.rate_sel_bit0};
  assign master_mode = ctrl_q.module_enable && ctrl_q.master_select;
  assign slave_mode = ctrl_q.module_enable && !ctrl_q.master_select;
  assign ss_n_sync = pin_sync_q[3];
  assign sck_sync = pin_sync_q[2];

  // phase one plus select-disable ignores the pin; the master owns the line
  assign selected = (ctrl_q.clk_phase && ctrl_q.select_disable) || !ss_n_sync;

  // transfer in progress, as seen by collision detection
  assign active = master_mode ? (mstate_q == spi_pkg::st_run)
                              : (slave_mode && selected && (edge_cnt_q != spi_pkg::edge_cnt_reset));

  // master starts only with a usable rate code
  assign start = master_mode && data_wr && (mstate_q == spi_pkg::st_idle)
                 && spi_pkg::rate_valid(rate_code);

  // serial clock edges: generated in master, observed in slave
  assign m_edge = (mstate_q == spi_pkg::st_run)
                  && (div_cnt_q == spi_pkg::half_period_m1(rate_code));
  assign s_edge = slave_mode && selected && (sck_sync != sck_prev_q);
  assign edge_now = m_edge || s_edge;

  // leading edge leaves the idle level
  assign is_lead = master_mode ? !edge_cnt_q[0] : (sck_sync != ctrl_q.clk_polarity);

  // phase zero samples on leading edges, phase one on trailing edges
  assign sample_edge = edge_now && (is_lead ^ ctrl_q.clk_phase);
  assign shift_edge = edge_now && !(is_lead ^ ctrl_q.clk_phase);

  // master samples its input line, slave samples the master's output
  assign in_bit = master_mode ? pin_sync_q[0] : pin_sync_q[1];
  assign shifted = {shift_q[6:0], in_bit};

  // master ends on the sixteenth edge, slave on its eighth sample; master flags two clocks late
  always_comb begin
    finish = 1'b0;
    if (master_mode) begin
      finish = m_edge && (edge_cnt_q == spi_pkg::edge_last);
    end else if (slave_mode) begin
      finish = sample_edge && (edge_cnt_q == (ctrl_q.clk_phase ? spi_pkg::edge_last
                                                               : spi_pkg::edge_last_lead));
    end
  end
  assign done_set = mfin_q[1] || (!master_mode && finish);

  // select falling in master mode means another master is on the bus
  assign mode_fault_flag_set = master_mode && !ctrl_q.select_disable
                    && ss_prev_q && !ss_n_sync;

  // two-step clearing sequences
  assign done_clr = data_rd && done_arm_q;
  assign write_collision_flag_clr = data_acc && write_collision_flag_arm_q;
  assign mode_fault_flag_clr = ctrl_wr && mode_fault_flag_arm_q;

  // two flops on every pin before any logic reads it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta_q <= 4'hf;
      pin_sync_q <= 4'hf;
    end else begin
      pin_meta_q <= {ss_n_i, sck_i, mosi_i, miso_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  // previous synchronised levels for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_prev_q <= 1'b1;
      ss_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_sync;
      ss_prev_q <= ss_n_sync;
    end
  end

  // control register; a mode fault overrides enable and master bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= spi_pkg::ctrl_reset;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= reg_wdata;
      end
      if (mode_fault_flag_set) begin
        ctrl_q.module_enable <= 1'b0;
        ctrl_q.master_select <= 1'b0;
      end
    end
  end

  // master engine: idle until a data write, run for sixteen edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mstate_q <= spi_pkg::st_idle;
    end else begin
      unique case (mstate_q)
        spi_pkg::st_idle: begin
          if (start) begin
            mstate_q <= spi_pkg::st_run;
          end
        end
        spi_pkg::st_run: begin
          // losing master mode aborts; a collision does not
          if (finish || !master_mode) begin
            mstate_q <= spi_pkg::st_idle;
          end
        end
        default: mstate_q <= spi_pkg::st_idle;
      endcase
    end
  end

  // baud divider counts peripheral clocks per half serial period
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_cnt_q <= spi_pkg::div_cnt_reset;
    end else if (mstate_q != spi_pkg::st_run || m_edge) begin
      div_cnt_q <= spi_pkg::div_cnt_reset;
    end else begin
      div_cnt_q <= div_cnt_q + 7'h01;
    end
  end

  // pin flops delay the master's input two clocks, so it is captured two clocks late
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msamp_q <= 2'h0;
      mfin_q <= 2'h0;
      mrx_q <= spi_pkg::data_reset;
    end else begin
      msamp_q <= {msamp_q[0], master_mode && sample_edge};
      mfin_q <= {mfin_q[0], master_mode && finish};
      if (msamp_q[1]) begin
        mrx_q <= {mrx_q[6:0], pin_sync_q[0]};
      end
    end
  end

  // generated clock level; idle level follows polarity when not running
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_lvl_q <= 1'b0;
    end else if (mstate_q != spi_pkg::st_run) begin
      sck_lvl_q <= ctrl_q.clk_polarity;
    end else if (m_edge) begin
      sck_lvl_q <= !sck_lvl_q;
    end
  end

  // edge counter; slave restarts it whenever it is not selected
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      edge_cnt_q <= spi_pkg::edge_cnt_reset;
    end else if (start) begin
      edge_cnt_q <= spi_pkg::edge_cnt_reset;
    end else if (slave_mode && !selected) begin
      edge_cnt_q <= spi_pkg::edge_cnt_reset;
    end else if (!master_mode && !slave_mode) begin
      edge_cnt_q <= spi_pkg::edge_cnt_reset;
    end else if (edge_now) begin
      edge_cnt_q <= edge_cnt_q + 4'h1;
    end
  end

  // shift register: sampling shifts in, idle data writes load it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_q <= spi_pkg::data_reset;
    end else if (sample_edge) begin
      shift_q <= shifted;
    end else if (data_wr && !active) begin
      // a write that lands mid-transfer is dropped, so the old byte goes out
      shift_q <= reg_wdata;
    end
  end

  // output bit moves on shift edges; an idle data write shows its msb at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_q <= 1'b0;
    end else if (data_wr && !active) begin
      out_q <= reg_wdata[7];
    end else if (shift_edge) begin
      out_q <= shift_q[7];
    end
  end

  // receive register is written in the same cycle the done flag rises
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_q <= spi_pkg::data_reset;
    end else if (mfin_q[1]) begin
      rx_q <= msamp_q[1] ? {mrx_q[6:0], pin_sync_q[0]} : mrx_q;
    end else if (finish && !master_mode) begin
      // overrun is not detected; the newest byte simply replaces the old one
      rx_q <= sample_edge ? shifted : shift_q;
    end
  end

  // done flag; a new completion beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      done_arm_q <= 1'b0;
    end else begin
      done_q <= done_set || (done_q && !done_clr);
      if (done_clr || (!done_q && !done_set)) begin
        done_arm_q <= 1'b0;
      end else if (status_rd && done_q) begin
        done_arm_q <= 1'b1;
      end
    end
  end

  // write collision flag; raises no request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      write_collision_flag_q <= 1'b0;
      write_collision_flag_arm_q <= 1'b0;
    end else begin
      write_collision_flag_q <= (data_wr && active) || (write_collision_flag_q && !write_collision_flag_clr);
      if (write_collision_flag_clr) begin
        write_collision_flag_arm_q <= 1'b0;
      end else if (status_acc && write_collision_flag_q) begin
        write_collision_flag_arm_q <= 1'b1;
      end
    end
  end

  // mode fault flag; only the read-then-control-write sequence clears it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_fault_flag_q <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end else begin
      // select-disable changes do not touch the flag
      mode_fault_flag_q <= mode_fault_flag_set || (mode_fault_flag_q && !mode_fault_flag_clr);
      if (mode_fault_flag_clr) begin
        mode_fault_flag_arm_q <= 1'b0;
      end else if (status_rd && mode_fault_flag_q) begin
        mode_fault_flag_arm_q <= 1'b1;
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        spi_pkg::ctrl_offset: rdata_q <= ctrl_q;
        spi_pkg::status_offset: begin
          rdata_q <= 8'h00;
          rdata_q[spi_pkg::status_done_pos] <= done_q;
          rdata_q[spi_pkg::status_write_collision_flag_pos] <= write_collision_flag_q;
          rdata_q[spi_pkg::status_mode_fault_flag_pos] <= mode_fault_flag_q;
        end
        spi_pkg::data_offset: rdata_q <= rx_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // pin drive; enables are active low
  assign sck_o = sck_lvl_q;
  assign sck_oe_n = !master_mode;
  assign mosi_o = out_q;
  assign mosi_oe_n = !master_mode;
  assign miso_o = out_q;
  assign miso_oe_n = !(slave_mode && selected);

  // error request follows the flag unless select is disabled
  assign err_req = mode_fault_flag_q && !ctrl_q.select_disable;

endmodule

// ===== tb/spi_master_slave_controller_properties.sv
// port-level assertion checker for the serial controller
`timescale 1ns/1ps
module spi_master_slave_controller_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic sck_o,
  input wire logic sck_oe_n,
  input wire logic mosi_o,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n,
  input wire logic ss_n_i,
  input wire logic err_req
);
  logic sd_q;
  logic ph_q;
  logic [1:0] quiet_q;
  wire ctrl_wr = reg_wr && (reg_addr == spi_pkg::ctrl_offset);
  spi_pkg::ctrl_t wr_ctrl;
  assign wr_ctrl = reg_wdata;

  // shadow of select-disable and phase; mode faults never touch these two bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sd_q <= 1'b0;
      ph_q <= 1'b0;
    end else if (ctrl_wr) begin
      sd_q <= wr_ctrl.select_disable;
      ph_q <= wr_ctrl.clk_phase;
    end
  end

  // cycles since the last control write, saturating; output enables lag the write
  always_ff @(posedge clk) begin
    if (sys_rst || ctrl_wr) begin
      quiet_q <= 2'h0;
    end else if (quiet_q != 2'h3) begin
      quiet_q <= quiet_q + 2'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // select must sit high past the two-flop synchroniser; the slave output enable itself is not registered
  sequence ss_held_high;
    ss_n_i [*5];
  endsequence
  sequence ctrl_settled;
    quiet_q == 2'h3;
  endsequence

  chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its read cycle");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_master_pins: assert property (!sck_oe_n |-> !mosi_oe_n && miso_oe_n)
    else $error("master drives the wrong pins");
  chk_slave_release: assert property (ss_held_high ##0 ctrl_settled |-> miso_oe_n || (sd_q && ph_q))
    else $error("deselected slave still drives its data pin");
  chk_sck_half: assert property (!sck_oe_n && $changed(sck_o) |=> $stable(sck_o))
    else $error("serial clock faster than divide by four");
  chk_mosi_on_edge: assert property (!mosi_oe_n && $changed(mosi_o) |-> $changed(sck_o) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("data out moved off a shift edge");
  chk_fault_cause: assert property ($rose(err_req) |-> !(ss_n_i && $past(ss_n_i) && $past(ss_n_i, 2) && $past(ss_n_i, 3) && $past(ss_n_i, 4)))
    else $error("error request without a low select");
  chk_err_clear: assert property ($fell(err_req) |-> $past(ctrl_wr))
    else $error("error request dropped without a control write");
endmodule

bind spi_master_slave_controller spi_master_slave_controller_properties u_props (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .mosi_o(mosi_o),
  .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n), .ss_n_i(ss_n_i), .err_req(err_req)
);

// ===== tb/spi_partner_model.sv
// behavioural far-side slave for master transfers, any polarity and phase
`timescale 1ns/1ps
module spi_partner_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic [7:0] sh_q;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    sh_q = 8'h00;
  end
  // select fall loads the byte; phase zero shows the msb at once
  always @(negedge sel_n) begin
    sh_q = tx_byte;
    if (!cpha) miso = tx_byte[7];
  end
  // released line: inverse of last value, so a stale bit never looks valid
  always @(posedge sel_n) miso = ~miso;
  // leading edge samples in phase zero, trailing in phase one
  always @(sck) begin
    if (!sel_n && ((sck != cpol) != cpha)) begin
      rx_byte = {rx_byte[6:0], mosi};
    end else if (!sel_n && cpha) begin
      miso = sh_q[7];
      sh_q = {sh_q[6:0], 1'b0};
    end else if (!sel_n) begin
      sh_q = {sh_q[6:0], 1'b0};
      miso = sh_q[7];
    end
  end
endmodule

// ===== tb/spi_master_slave_controller_bench.sv
// self-checking bench: register port, master transfers, select and fault handling
`timescale 1ns/1ps
module spi_master_slave_controller_bench;
  logic clk, sys_rst, reg_wr, reg_rd, ss_n, part_sel_n, cpol, cpha;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, part_tx, part_rx, tx, rx, prev;
  logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, err_req, part_miso;
  logic sck_drv, mosi_drv;
  wire sck_w = sck_oe_n ? sck_drv : sck_o;
  wire mosi_w = mosi_oe_n ? mosi_drv : mosi_o;
  wire miso_w = miso_oe_n ? part_miso : miso_o;
  int mismatches, checked, cycles;

  spi_master_slave_controller u_spi_master_slave_controller (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_i(sck_w),
    .sck_o(sck_o), .sck_oe_n(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_n(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
    .ss_n_i(ss_n), .err_req(err_req));
  spi_partner_model u_spi_partner_model (
    .sck(sck_w), .mosi(mosi_w), .sel_n(part_sel_n), .cpol(cpol), .cpha(cpha),
    .tx_byte(part_tx), .miso(part_miso), .rx_byte(part_rx));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(what, exp, reg_rdata);
  endtask
  // one master byte; codes zero and seven must not start the clock
  task automatic xfer(input logic [2:0] code, input logic pol, input logic ph, input logic col);
    logic ok;
    ok = (code != 3'h0) && (code != 3'h7);
    tx = 8'($urandom());
    rx = 8'($urandom());
    prev = part_rx;
    cpol <= pol;
    cpha <= ph;
    part_tx <= rx;
    wr(spi_pkg::ctrl_offset, {code[2], 3'b111, pol, ph, code[1:0]});
    // select only after the idle clock has taken the new polarity
    repeat (2) @(posedge clk);
    part_sel_n <= 1'b0;
    wr(spi_pkg::data_offset, tx);
    repeat (6) @(posedge clk);
    if (col) wr(spi_pkg::data_offset, ~tx);
    repeat (ok ? 16 << code : 16) @(posedge clk);
    rd(spi_pkg::status_offset, ok ? {1'b1, col, 6'h00} : 8'h00, "status");
    if (ok) rd(spi_pkg::data_offset, rx, "rx byte");
    rd(spi_pkg::status_offset, 8'h00, "status cleared");
    check("far rx", ok ? tx : prev, part_rx);
    check("idle sck", {7'h00, pol}, sck_o);
    part_sel_n <= 1'b1;
  endtask

  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, cpol, cpha, part_tx, sck_drv, mosi_drv} = '0;
    {ss_n, part_sel_n} = 2'b11;
    {mismatches, checked, cycles} = '0;
    void'($urandom(32'h9be8));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(spi_pkg::ctrl_offset, spi_pkg::ctrl_reset, "ctrl reset");
    rd(spi_pkg::status_offset, 8'h00, "status reset");
    check("sck oe reset", 8'h01, sck_oe_n);
    rd(2'h3, 8'h00, "unmapped");
    wr(spi_pkg::status_offset, 8'hff);
    rd(spi_pkg::status_offset, 8'h00, "status read only");
    for (int c = 0; c < 8; c++) xfer(3'(c), 1'($urandom()), 1'($urandom()), c == 1);
    repeat (6) xfer(3'(1 + $urandom() % 3), 1'($urandom()), 1'($urandom()), 1'b0);
    // select disabled: a low select is no fault
    wr(spi_pkg::ctrl_offset, 8'h71);
    ss_n <= 1'b0;
    settle(6);
    rd(spi_pkg::status_offset, 8'h00, "no fault");
    ss_n <= 1'b1;
    settle(5);
    wr(spi_pkg::ctrl_offset, 8'h51);
    ss_n <= 1'b0;
    settle(6);
    check("err req", 8'h01, err_req);
    rd(spi_pkg::ctrl_offset, 8'h01, "ctrl after fault");
    wr(spi_pkg::ctrl_offset, 8'h20);
    wr(spi_pkg::ctrl_offset, 8'h00);
    settle(1);
    check("err kept", 8'h01, err_req);
    rd(spi_pkg::status_offset, 8'h10, "fault flag");
    wr(spi_pkg::ctrl_offset, 8'h00);
    rd(spi_pkg::status_offset, 8'h00, "fault cleared");
    ss_n <= 1'b1;
    // slave data pin follows select unless phase and disable are both set
    wr(spi_pkg::ctrl_offset, 8'h40);
    settle(5);
    check("slave oe off", 8'h01, miso_oe_n);
    ss_n <= 1'b0;
    settle(5);
    check("slave oe on", 8'h00, miso_oe_n);
    ss_n <= 1'b1;
    wr(spi_pkg::ctrl_offset, 8'h64);
    settle(5);
    check("always selected", 8'h00, miso_oe_n);
    wr(spi_pkg::ctrl_offset, 8'h24);
    settle(5);
    check("disabled oe", 8'h01, miso_oe_n);
    // slave byte in phase one: bench plays master, eight clocks per half period
    tx = 8'($urandom());
    rx = 8'($urandom());
    wr(spi_pkg::ctrl_offset, 8'h44);
    wr(spi_pkg::data_offset, tx);
    ss_n <= 1'b0;
    settle(4);
    for (int b = 7; b >= 0; b--) begin
      sck_drv <= 1'b1;
      mosi_drv <= rx[b];
      settle(8);
      prev[b] = miso_w;
      sck_drv <= 1'b0;
      settle(8);
    end
    check("slave out", tx, prev);
    rd(spi_pkg::status_offset, 8'h80, "slave done");
    rd(spi_pkg::data_offset, rx, "slave rx");
    ss_n <= 1'b1;
    give_verdict();
  end
endmodule
